// ==== hw/flash_access_and_program_control.sv ====
// Purpose: flash read timing, prefetch and erase/program sequencing
// Assumes: requester holds rd_req until rd_ready; commands are one-cycle pulses
// Notes:   a module read within the last few cycles counts as being read
// Operation
// RULE1 - software sets wait states by clock: 1, 2, 3, 4 above 17 MHz
// RULE2 - wait states apply only to non-sequential reads
// RULE3 - prefetch fetches the next sequential word ahead of the request
// RULE4 - after reset every word reads erased and nothing is protected
// RULE5 - a module being read must not be erased or programmed
// RULE6 - two concurrent operations with at most one module read, else one
// RULE7 - second module accepts operations while another module or sram is read
// RULE8 - page erase finishes typically 7 ms, at most 8.0 ms, then busy clears
// RULE9 - page program finishes typically 3 ms, at most 3.5 ms
// RULE10 - durations come from the flash timebase plus a few cycles overhead
// RULE11 - software raises wait states before raising clock, lowers after
`timescale 1ns/1ps
`default_nettype none
module flash_access_and_program_control #(
   parameter int NM = flash_ctrl_pkg::NUM_MODULES,
   parameter int WW = flash_ctrl_pkg::WORD_W,
   parameter int PW = flash_ctrl_pkg::PAGE_W,
   parameter int DW = flash_ctrl_pkg::DATA_W,
   parameter int unsigned ERASE_CYCLES = flash_ctrl_pkg::ERASE_TYP_CYC,
   parameter int unsigned PROG_CYCLES = flash_ctrl_pkg::PROG_TYP_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [flash_ctrl_pkg::WS_W-1:0] flash_wait_state_count,
   input wire logic program_sram_read,
   input wire logic rd_req,
   input wire logic [$clog2(NM)+WW-1:0] rd_addr,
   output logic rd_ready,
   output logic rd_valid,
   output logic rd_err,
   output logic [DW-1:0] rd_data,
   input wire logic cmd_valid,
   input wire flash_ctrl_pkg::op_e cmd_op,
   input wire logic [$clog2(NM)+WW-1:0] cmd_addr,
   input wire logic [DW-1:0] cmd_data,
   output logic cmd_accept,
   output logic cmd_reject,
   output logic [NM-1:0] module_busy,
   output logic [NM-1:0] op_done
);
   import flash_ctrl_pkg::*;
   localparam int MW = $clog2(NM);
   localparam int AW = MW + WW;
   localparam int DEPTH = NM << WW;

   function automatic int unsigned ones(input logic [NM-1:0] v);
      int unsigned n;
      n = 0;
      for (int i = 0; i < NM; i++) n += int'(v[i]);
      return n;
   endfunction

   function automatic logic [MW-1:0] mod_of(input logic [AW-1:0] a);
      return a[AW-1:WW];
   endfunction

   // next word in the same module, wrapping at its end
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
      return {a[AW-1:WW], a[WW-1:0] + WW'(1)};
   endfunction

   logic [DW-1:0] mem [DEPTH];
   rd_state_e rd_state;
   logic [WS_W-1:0] rd_cnt, pf_cnt;
   logic [AW-1:0] rd_addr_q, pf_addr;
   logic pf_valid, pf_pend, take, hit, seq, cmd_ok;
   logic [HOLD_W-1:0] hold [NM];
   logic [NM-1:0] rd_active, recent, start, tmr_done;
   op_e op_kind [NM];
   logic [AW-1:0] op_addr [NM];
   logic [DW-1:0] op_data [NM];
   logic [CNT_W-1:0] op_len [NM];
   logic [CNT_W-1:0] busy_cyc [NM];
   logic [CNT_W-1:0] cmd_len;
   int unsigned n_rd, n_busy, limit;

   // ----------------------------------------------------------------
   // request decode and admission of erase/program commands
   // ----------------------------------------------------------------
   always_comb begin
      take = rd_req && rd_ready;
      hit = pf_valid && rd_addr == pf_addr;
      seq = pf_pend && rd_addr == pf_addr;
      for (int m = 0; m < NM; m++) begin
         recent[m] = hold[m] != '0;
         rd_active[m] = recent[m] || (rd_req && mod_of(rd_addr) == MW'(m));
      end
      n_rd = ones(recent);
      n_busy = ones(module_busy);
      limit = (n_rd <= RD_LIMIT) ? PAR_LIMIT_LOW_RD : PAR_LIMIT_HIGH_RD; // RULE6
      // program sram reads never block a flash module
      cmd_ok = !module_busy[mod_of(cmd_addr)] && !rd_active[mod_of(cmd_addr)] // RULE5 RULE7
               && n_busy < limit; // RULE6
      cmd_len = (cmd_op == OP_ERASE) ? CNT_W'(ERASE_CYCLES) + OVERHEAD_CYC // RULE8 RULE10
                                     : CNT_W'(PROG_CYCLES) + OVERHEAD_CYC; // RULE9
      for (int m = 0; m < NM; m++) start[m] = ce && cmd_valid && cmd_ok && mod_of(cmd_addr) == MW'(m);
   end

   // ----------------------------------------------------------------
   // read path: wait states on misses, prefetch one word ahead
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_state <= RD_IDLE;
         rd_ready <= 1'b1;
         rd_valid <= 1'b0;
         rd_err <= 1'b0;
         rd_data <= '0;
         rd_cnt <= '0;
         rd_addr_q <= '0;
         pf_valid <= 1'b0;
         pf_pend <= 1'b0;
         pf_cnt <= '0;
         pf_addr <= '0;
      end else if (ce) begin
         rd_valid <= 1'b0;
         rd_err <= 1'b0;
         // background fetch of the next word
         if (pf_pend) begin
            if (pf_cnt == '0) begin
               pf_valid <= 1'b1; // RULE3
               pf_pend <= 1'b0;
            end else begin
               pf_cnt <= pf_cnt - WS_W'(1);
            end
         end
         case (rd_state)
            RD_IDLE: begin
               if (rd_req) begin
                  rd_addr_q <= rd_addr;
                  if (module_busy[mod_of(rd_addr)]) begin
                     rd_valid <= 1'b1; // RULE5
                     rd_err <= 1'b1;
                     pf_valid <= 1'b0;
                     pf_pend <= 1'b0;
                  end else if (hit) begin
                     rd_valid <= 1'b1; // RULE2 RULE3
                     rd_data <= mem[rd_addr];
                     pf_addr <= next_addr(rd_addr);
                     pf_pend <= 1'b1;
                     pf_valid <= 1'b0;
                     pf_cnt <= flash_wait_state_count;
                  end else begin
                     rd_state <= RD_WAIT;
                     rd_ready <= 1'b0;
                     // a sequential request only waits for what the prefetch still needs
                     rd_cnt <= seq ? pf_cnt : flash_wait_state_count; // RULE2
                     pf_valid <= 1'b0;
                     pf_pend <= 1'b0;
                  end
               end
            end
            RD_WAIT: begin
               if (rd_cnt == '0) begin
                  rd_state <= RD_IDLE;
                  rd_ready <= 1'b1;
                  rd_valid <= 1'b1;
                  rd_data <= mem[rd_addr_q];
                  pf_addr <= next_addr(rd_addr_q); // RULE3
                  pf_pend <= 1'b1;
                  pf_valid <= 1'b0;
                  pf_cnt <= flash_wait_state_count;
               end else begin
                  rd_cnt <= rd_cnt - WS_W'(1);
               end
            end
            default: rd_state <= RD_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // per-module read activity, kept alive while a fetch is in flight
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int m = 0; m < NM; m++) hold[m] <= '0;
      end else if (ce) begin
         for (int m = 0; m < NM; m++) begin
            if ((take && mod_of(rd_addr) == MW'(m)) ||
                (rd_state == RD_WAIT && mod_of(rd_addr_q) == MW'(m)) ||
                (pf_pend && mod_of(pf_addr) == MW'(m)))
               hold[m] <= READ_HOLD; // RULE5
            else if (hold[m] != '0)
               hold[m] <= hold[m] - HOLD_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // command answer and operation capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_accept <= 1'b0;
         cmd_reject <= 1'b0;
         op_done <= '0;
         for (int m = 0; m < NM; m++) begin
            op_kind[m] <= OP_ERASE;
            op_addr[m] <= '0;
            op_data[m] <= '0;
            op_len[m] <= '0;
         end
      end else if (ce) begin
         cmd_accept <= cmd_valid && cmd_ok;
         cmd_reject <= cmd_valid && !cmd_ok; // RULE5 RULE6
         op_done <= tmr_done;
         for (int m = 0; m < NM; m++) begin
            if (start[m]) begin
               op_kind[m] <= cmd_op;
               op_addr[m] <= cmd_addr;
               op_data[m] <= cmd_data;
               op_len[m] <= cmd_len;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // array contents; erase writes the whole page, program clears bits only
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '1; // RULE4
      end else if (ce) begin
         for (int m = 0; m < NM; m++) begin
            if (tmr_done[m]) begin
               if (op_kind[m] == OP_ERASE) begin
                  for (int w = 0; w < (1 << PW); w++)
                     mem[{op_addr[m][AW-1:PW], PW'(w)}] <= '1; // RULE8
               end else begin
                  mem[op_addr[m]] <= mem[op_addr[m]] & op_data[m]; // RULE9
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // one timer per module, plus a duration counter for checking
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NM; g++) begin : g_mod
      flash_op_timer #(.CW(CNT_W)) u_timer (
         .clk(clk),
         .sys_rst(sys_rst),
         .ce(ce),
         .start(start[g]),
         .load(cmd_len),
         .busy(module_busy[g]),
         .done(tmr_done[g])
      );

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            busy_cyc[g] <= '0;
         end else if (ce) begin
            if (start[g]) busy_cyc[g] <= '0;
            else if (module_busy[g]) busy_cyc[g] <= busy_cyc[g] + CNT_W'(1);
         end
      end

      chk_erase_duration: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
         (tmr_done[g] && op_kind[g] == OP_ERASE) |-> busy_cyc[g] == CNT_W'(ERASE_CYCLES) + OVERHEAD_CYC)
         else $error("erase duration differs from its count");
      chk_prog_duration: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
         (tmr_done[g] && op_kind[g] == OP_PROGRAM) |->
         busy_cyc[g] == op_len[g] && op_len[g] == CNT_W'(PROG_CYCLES) + OVERHEAD_CYC)
         else $error("program duration differs from its count");
   end

   // ----------------------------------------------------------------
   // checks on the read path and admission
   // ----------------------------------------------------------------
   logic [WS_W:0] lat;
   logic [WS_W-1:0] ws_q;
   logic miss_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lat <= '0;
         ws_q <= '0;
         miss_q <= 1'b0;
      end else if (ce) begin
         if (rd_state == RD_IDLE && rd_req) begin
            lat <= '0;
            ws_q <= flash_wait_state_count;
            miss_q <= !hit && !seq && !module_busy[mod_of(rd_addr)];
         end else if (rd_state == RD_WAIT) begin
            lat <= lat + (WS_W+1)'(1);
         end
      end
   end

   sequence s_hit_take;
      ce && rd_state == RD_IDLE && rd_req && hit && !module_busy[mod_of(rd_addr)];
   endsequence
   sequence s_hit_answer;
      rd_valid && !rd_err && rd_ready;
   endsequence

   chk_nonseq_wait: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
      (rd_valid && miss_q && $past(rd_state) == RD_WAIT) |-> lat == {1'b0, ws_q} + (WS_W+1)'(1))
      else $error("non-sequential read latency wrong");
   chk_prefetch_hit: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
      s_hit_take |=> s_hit_answer)
      else $error("prefetched word not answered next cycle");
   chk_erased_reset: assert property (@(posedge clk) // RULE4
      sys_rst |=> (mem[0] == '1 && module_busy == '0 && !cmd_accept))
      else $error("array not erased after reset");
   chk_busy_unread: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
      (rd_valid && !rd_err) |-> !module_busy[mod_of(rd_addr_q)])
      else $error("read served from a busy module");
   chk_par_limit: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
      (ce && cmd_valid && n_busy >= limit) |=> cmd_reject && !cmd_accept)
      else $error("parallel operation limit exceeded");
   chk_other_module: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
      (ce && cmd_valid && !rd_active[mod_of(cmd_addr)] && !module_busy[mod_of(cmd_addr)] && n_busy == 0)
      |=> cmd_accept ##1 module_busy != '0)
      else $error("idle module refused an operation");
   // sram reads must never hold back an operation on an unread flash module
   chk_sram_reads: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
      (ce && cmd_valid && program_sram_read && !rd_active[mod_of(cmd_addr)] && !module_busy[mod_of(cmd_addr)]
       && n_busy == 0) |=> cmd_accept)
      else $error("operation refused during sram reads");
endmodule // flash_access_and_program_control
`default_nettype wire

// ==== hw/flash_op_timer.sv ====
// Purpose: counts one erase or program duration for a single flash module
// Assumes: load is at least one; start is ignored while busy
// Notes:   done is a one-cycle pulse raised on the same edge that busy falls
`timescale 1ns/1ps
`default_nettype none
module flash_op_timer #(
   parameter int CW = flash_ctrl_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic start,
   input wire logic [CW-1:0] load,
   output logic busy,
   output logic done
);
   import flash_ctrl_pkg::*;
   logic [CW-1:0] cnt;

   // ----------------------------------------------------------------
   // down counter, busy for exactly load cycles
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            cnt <= load; // RULE10
         end else if (busy) begin
            if (cnt == CW'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            cnt <= cnt - CW'(1);
         end
      end
   end

   property p_load;
      @(posedge clk) disable iff (sys_rst)
      (ce && start && !busy) |=> (busy && cnt == $past(load));
   endproperty
   chk_timer_load_start: assert property (p_load) else $error("timer did not load its duration"); // RULE10
endmodule // flash_op_timer
`default_nettype wire

// ==== shared/flash_ctrl_pkg.sv ====
// Purpose: shared constants and types for the flash access and program control block
// Assumes: 200 MHz system clock, durations given in microseconds
// Notes:   cycle counts follow from the nominal times and the clock rate
`default_nettype none
package flash_ctrl_pkg;
   // ----------------------------------------------------------------
   // clock and operation timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned ERASE_TYP_US = 7000;
   localparam int unsigned ERASE_MAX_US = 8000;
   localparam int unsigned PROG_TYP_US = 3000;
   localparam int unsigned PROG_MAX_US = 3500;
   localparam int unsigned ERASE_TYP_CYC = ERASE_TYP_US * CLK_MHZ;
   localparam int unsigned ERASE_MAX_CYC = ERASE_MAX_US * CLK_MHZ; // longest time, exact
   localparam int unsigned PROG_TYP_CYC = PROG_TYP_US * CLK_MHZ;
   localparam int unsigned PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
   localparam int CNT_W = 22;
   localparam logic [CNT_W-1:0] OVERHEAD_CYC = 22'h4; // sequencer bookkeeping cycles

   // ----------------------------------------------------------------
   // geometry and read path
   // ----------------------------------------------------------------
   localparam int NUM_MODULES = 2;
   localparam int WORD_W = 6;
   localparam int PAGE_W = 3;
   localparam int DATA_W = 16;
   localparam int WS_W = 4;
   localparam int HOLD_W = 5;
   localparam logic [HOLD_W-1:0] READ_HOLD = 5'h10; // idle cycles until a module counts as unread
   localparam int unsigned RD_LIMIT = 1;
   localparam int unsigned PAR_LIMIT_LOW_RD = 2;
   localparam int unsigned PAR_LIMIT_HIGH_RD = 1;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic {OP_ERASE = 1'b0, OP_PROGRAM = 1'b1} op_e;
   typedef enum logic {RD_IDLE = 1'b0, RD_WAIT = 1'b1} rd_state_e;
endpackage
`default_nettype wire

// ==== test/core_read_model.sv ====
// Purpose: behavioural read requester standing in for the core on the flash read port
// Assumes: single clock, one read outstanding, requests raised at the falling edge
// Notes:   address lines show the inverse of the last value once released
`timescale 1ns/1ps
`default_nettype none
module core_read_model
   import flash_ctrl_pkg::*;
#(
   parameter int AW = 7
) (
   input wire logic clk,
   output logic rd_req,
   output logic [AW-1:0] rd_addr,
   input wire logic rd_ready,
   input wire logic rd_valid,
   input wire logic rd_err,
   input wire logic [DATA_W-1:0] rd_data
);
   // ----------------------------------------------------------------
   // idle levels at time zero
   // ----------------------------------------------------------------
   initial begin
      rd_req = 1'b0;
      rd_addr = '0;
   end

   // one read: hold request until answered, count edges from raise to answer
   // may also read a module that is being modified, which is answered with rd_err
   task automatic read(input logic [AW-1:0] a, output logic [DATA_W-1:0] d, output logic e, output int lat);
      int n;
      begin
         n = 0;
         @(negedge clk);
         rd_req = 1'b1;
         rd_addr = a;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (rd_valid !== 1'b1 && n < 64);
         d = rd_data;
         e = rd_err;
         lat = n;
         @(negedge clk);
         rd_req = 1'b0;
         rd_addr = ~a; // stale address must not look valid
      end
   endtask
endmodule // core_read_model
`default_nettype wire

// ==== test/tb_flash_access_and_program_control.sv ====
// Purpose: self-checking bench for flash read timing, prefetch and erase/program sequencing
// Assumes: shortened erase and program counts, clock 200 MHz
// Notes:   latencies are compared as differences where the absolute offset is a design choice
`timescale 1ns/1ps
`default_nettype none
module tb_flash_access_and_program_control;
   import flash_ctrl_pkg::*;
   localparam int EC = 20;
   localparam int PC = 10;
   localparam int OVH = int'(OVERHEAD_CYC);
   logic clk, sys_rst, ce, program_sram_read, rd_req, rd_ready, rd_valid, rd_err;
   logic cmd_valid, cmd_accept, cmd_reject;
   logic [3:0] flash_wait_state_count;
   logic [6:0] rd_addr, cmd_addr;
   logic [15:0] rd_data, cmd_data;
   op_e cmd_op;
   logic [1:0] module_busy, op_done;
   int err_total, checks_done, cyc;
   logic [15:0] d;
   logic e, acc, rej;
   int l1, l2;

   flash_access_and_program_control #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) i_flash_access_and_program_control (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .flash_wait_state_count(flash_wait_state_count),
      .program_sram_read(program_sram_read), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
      .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
      .module_busy(module_busy), .op_done(op_done));
   core_read_model #(.AW(7)) core (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
      .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic chk_data(input string n, input logic [15:0] x, input logic [15:0] s);
      checks_done++;
      if (s !== x) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic chk_bit(input string n, input logic x, input logic s);
      checks_done++;
      if (s !== x) begin
         err_total++;
         $display("unexpected %s expected %b seen %b", n, x, s);
      end
   endtask
   task automatic chk_num(input string n, input int x, input int s);
      checks_done++;
      if (s != x) begin
         err_total++;
         $display("unexpected %s expected %0d seen %0d", n, x, s);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // leaves cmd_valid up so a second command can follow at once
   task automatic cmd_issue(input op_e op, input logic [6:0] a, input logic [15:0] v);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = v;
      @(posedge clk);
      #1;
      acc = cmd_accept;
      rej = cmd_reject;
   endtask
   task automatic cmd_end;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_addr = ~cmd_addr;
      cmd_data = ~cmd_data;
   endtask
   // counts edges until the module's busy falls, then checks the done pulse
   task automatic busy_len(input int m, input int start, output int n);
      n = start;
      while (module_busy[m] === 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      chk_bit("op_done", 1'b1, op_done[m]);
   endtask
   task automatic wait_free;
      int n;
      n = 0;
      while (module_busy !== 2'b00 && n < 200) begin
         @(negedge clk);
         n++;
      end
      idle(40); // lets read activity age out of the hold window
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_delivered;
      chk_data("module_busy", 16'h0, {14'h0, module_busy});
      chk_bit("rd_ready", 1'b1, rd_ready);
      core.read(7'h05, d, e, l1);
      chk_data("rd_data", 16'hffff, d);
      chk_bit("rd_err", 1'b0, e);
      idle(40);
      cmd_issue(OP_PROGRAM, 7'h07, 16'h1234);
      cmd_end;
      chk_bit("cmd_accept", 1'b1, acc);
      wait_free;
      $display("test delivered done");
   endtask
   task automatic t_wait_states;
      flash_wait_state_count = 4'h1;
      idle(10);
      core.read(7'h10, d, e, l1);
      flash_wait_state_count = 4'h4;
      idle(10);
      core.read(7'h30, d, e, l2);
      chk_num("miss latency step", 3, l2 - l1);
      idle(10);
      core.read(7'h31, d, e, l1);
      chk_num("hit latency", 1, l1);
      chk_data("rd_data", 16'hffff, d);
      $display("test wait_states done");
   endtask
   task automatic t_prog_erase;
      int n;
      idle(40);
      cmd_issue(OP_PROGRAM, 7'h43, 16'h5a3c);
      cmd_end;
      chk_bit("cmd_accept", 1'b1, acc);
      busy_len(1, 0, n);
      chk_num("program busy", PC + OVH, n);
      core.read(7'h43, d, e, l1);
      chk_data("rd_data", 16'h5a3c, d);
      idle(40);
      cmd_issue(OP_ERASE, 7'h40, 16'h0000);
      cmd_end;
      // read of the busy module through the core model, answered with an error
      core.read(7'h45, d, e, l1);
      chk_bit("rd_err", 1'b1, e);
      chk_num("busy read latency", 1, l1);
      busy_len(1, 2, n);
      chk_bit("cmd_accept", 1'b1, acc);
      chk_num("erase busy", EC + OVH, n);
      core.read(7'h43, d, e, l1);
      chk_data("rd_data", 16'hffff, d);
      $display("test prog_erase done");
   endtask
   task automatic t_concurrency;
      idle(40);
      program_sram_read = 1'b1;
      core.read(7'h02, d, e, l1);
      cmd_issue(OP_ERASE, 7'h00, 16'h0000);
      chk_bit("cmd_reject", 1'b1, rej);
      cmd_issue(OP_PROGRAM, 7'h48, 16'h00ff);
      cmd_end;
      chk_bit("cmd_accept", 1'b1, acc);
      wait_free;
      program_sram_read = 1'b0;
      cmd_issue(OP_ERASE, 7'h08, 16'h0000);
      chk_bit("cmd_accept", 1'b1, acc);
      cmd_issue(OP_ERASE, 7'h50, 16'h0000);
      chk_bit("cmd_accept", 1'b1, acc);
      chk_data("module_busy", 16'h3, {14'h0, module_busy});
      cmd_issue(OP_PROGRAM, 7'h01, 16'h0000);
      cmd_end;
      chk_bit("cmd_reject", 1'b1, rej);
      wait_free;
      $display("test concurrency done");
   endtask

   // ----------------------------------------------------------------
   // clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard: the whole run needs well under a few thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         results;
      end
   end
   initial begin
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      sys_rst = 1'b1;
      ce = 1'b1;
      flash_wait_state_count = 4'h4;
      program_sram_read = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_ERASE;
      cmd_addr = 7'h00;
      cmd_data = 16'h0000;
      repeat (5) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      t_delivered;
      t_wait_states;
      t_prog_erase;
      t_concurrency;
      results;
   end
endmodule // tb_flash_access_and_program_control
`default_nettype wire
